// ---- core/spa_dev.sv ----
// Device end: command decode, protection and storage of the security page
`timescale 1ns/1ps
module spa_dev (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire logic             wp_n_i,
  spa_spi_if.dev                spi,
  output logic                  locked_o,
  output logic                  busy_o,
  output logic                  write_permit_latch_o,
  output logic                  guard_scheme_select_o
);
  import spa_pkg::*;

  spa_dev_st_t s;
  spa_dev_st_t n;

  logic [7:0]  user_mem [PAGE_BYTES];
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [255:0] pend;

  logic        rise;
  logic        fall;
  logic        cs_end;
  logic        aligned;
  logic        pin_guard;
  logic        start;
  logic        commit;
  logic        buf_we;
  logic [7:0]  in_byte;
  logic [7:0]  ob;

  // ****************************************
  // Outgoing byte selection
  // ****************************************
  always_comb begin
    if (s.op == OP_STATUS_READ) begin
      ob = {s.honor, 3'b000, s.guard, s.write_permit_latch, s.busy};
    end else if (s.op == OP_BUSY_POLL) begin
      ob = s.busy ? 8'hFF : 8'h00;
    end else if (s.a10) begin
      ob = {7'h00, s.locked};
    end else if (s.addr[8]) begin
      ob = user_mem[s.addr[7:0]];
    end else if (s.addr[7:4] == 4'h0) begin
      ob = SERIAL_NUMBER[{~s.addr[3:0], 3'b000} +: 8];
    end else begin
      ob = RESERVED_BYTE;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n         = s;
    n.wp_s1   = ~wp_n_i;
    n.wp_s2   = s.wp_s1;
    n.sclk_q  = spi.sclk;
    n.cs_q    = spi.cs_n;
    rise      = ~spi.cs_n & spi.sclk & ~s.sclk_q;
    fall      = ~spi.cs_n & ~spi.sclk & s.sclk_q;
    cs_end    = spi.cs_n & ~s.cs_q;
    in_byte   = {s.sh[6:0], spi.mosi};
    pin_guard = s.honor & s.wp_s2;
    aligned   = (s.phase == DP_DATA) && (s.cnt[2:0] == 3'd0);
    start     = 1'b0;
    commit    = 1'b0;
    buf_we    = 1'b0;

    if (s.busy) begin
      if (s.bcnt == 16'h0000) begin
        n.busy = 1'b0;
        n.write_permit_latch  = 1'b0;
      end else begin
        n.bcnt = s.bcnt - 16'h0001;
      end
    end

    if (rise) begin
      n.sh  = {s.sh[22:0], spi.mosi};
      n.cnt = s.cnt + 5'd1;
      case (s.phase)
        DP_OP: begin
          if (s.cnt == 5'd7) begin
            n.op  = in_byte;
            n.cnt = 5'd0;
            if (s.busy && in_byte != OP_STATUS_READ && in_byte != OP_BUSY_POLL) begin
              n.phase = DP_SKIP;
            end else if (in_byte == OP_ID_READ || in_byte == OP_ID_WRITE) begin
              n.phase = DP_ADDR;
            end else if (in_byte == OP_STATUS_READ || in_byte == OP_BUSY_POLL) begin
              n.phase = DP_OUT;
              n.obit  = 3'd0;
            end else begin
              n.phase = DP_DATA;
            end
          end
        end
        DP_ADDR: begin
          if (s.cnt == 5'd23) begin
            n.addr  = {s.sh[7:0], spi.mosi};
            n.a10   = s.sh[9];
            n.cnt   = 5'd0;
            n.obit  = 3'd0;
            n.phase = (s.op == OP_ID_READ) ? DP_OUT : DP_DATA;
          end
        end
        DP_DATA: begin
          n.cnt = {2'b00, s.cnt[2:0] + 3'd1};
          if (s.cnt[2:0] == 3'd7) begin
            if (s.nbytes == 2'd0) begin
              n.b0 = in_byte;
            end
            if (s.nbytes == 2'd1) begin
              n.b1 = in_byte;
            end
            if (s.nbytes != 2'd3) begin
              n.nbytes = s.nbytes + 2'd1;
            end
            if (s.op == OP_ID_WRITE && !s.a10) begin
              buf_we          = 1'b1;
              // Low byte only: a long page write rolls over inside the page
              n.addr[7:0] = s.addr[7:0] + 8'd1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (fall && s.phase == DP_OUT) begin
      if (s.obit == 3'd0) begin
        n.miso = ob[7];
        n.osr  = {ob[6:0], 1'b0};
        if (s.op == OP_ID_READ && !s.a10) begin
          n.addr = s.addr + 9'd1;
        end
      end else begin
        n.miso = s.osr[7];
        n.osr  = {s.osr[6:0], 1'b0};
      end
      n.obit = s.obit + 3'd1;
    end

    // Anything not ending on a byte edge of a data phase is dropped
    if (cs_end) begin
      if (aligned) begin
        case (s.op)
          OP_WRITE_PERMIT: begin
            if (s.nbytes == 2'd0) begin
              n.write_permit_latch = 1'b1;
            end
          end
          OP_STATUS_WRITE: begin
            if (s.nbytes != 2'd0 && s.write_permit_latch && !(s.scheme && pin_guard)) begin
              n.honor = s.b0[7];
              n.guard = s.b0[3:2];
              if (s.nbytes != 2'd1 && !s.frozen) begin
                n.scheme = s.b1[7];
              end
              start = 1'b1;
            end
          end
          OP_FREEZE: begin
            if (s.nbytes == 2'd0 && s.write_permit_latch) begin
              n.frozen = 1'b1;
              start    = 1'b1;
            end
          end
          OP_ID_WRITE: begin
            if (s.a10) begin
              if (s.nbytes != 2'd0 && s.b0[1] && s.write_permit_latch && !pin_guard) begin
                n.locked = 1'b1;
                start    = 1'b1;
              end
            end else if (s.nbytes != 2'd0 && s.write_permit_latch && !s.locked && s.addr[8]
                         && !(!s.scheme && s.guard == GUARD_ALL)) begin
              commit = 1'b1;
              start  = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      n.phase  = DP_OP;
      n.cnt    = 5'd0;
      n.nbytes = 2'd0;
      n.miso   = 1'b0;
    end

    if (start) begin
      n.busy = 1'b1;
      n.bcnt = 16'(WRITE_CYCLES - 1);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s      <= '0;
      s.cs_q <= 1'b1;
    end else if (ce_i) begin
      s <= n;
    end
  end

  // ****************************************
  // Page staging and user half storage
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (ce_i && buf_we) begin
      page_buf[s.addr[7:0]] <= in_byte;
    end
  end

  // Staged bytes land only at cycle start, so an aborted frame leaves no trace
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        user_mem[i] <= ERASED_BYTE;
      end
    end else if (ce_i) begin
      if (commit) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (pend[i]) begin
            user_mem[i] <= page_buf[i];
          end
        end
      end
      if (cs_end) begin
        pend <= '0;
      end else if (buf_we) begin
        pend[s.addr[7:0]] <= 1'b1;
      end
    end
  end

  assign spi.miso              = s.miso;
  assign locked_o              = s.locked;
  assign busy_o                = s.busy;
  assign write_permit_latch_o  = s.write_permit_latch;
  assign guard_scheme_select_o = s.scheme;

endmodule : spa_dev

// ---- core/spa_host.sv ----
// Host end: byte-level serial controller behind a plain register port
`timescale 1ns/1ps
module spa_host (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [7:0]            rdata_o,
  spa_spi_if.host               spi
);
  import spa_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(HALF_CYCLES - 1);

  spa_host_st_t s;
  spa_host_st_t n;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    n.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        REG_DATA: n.rdata = s.rx_last;
        REG_STAT: n.rdata = {6'h00, ~s.cs_n, s.phase == HP_SHIFT};
        default:  n.rdata = 8'h00;
      endcase
    end
    // Writes during a shift are dropped so chip select only rises on a byte edge
    if (wr_i && s.phase == HP_IDLE) begin
      if (addr_i == REG_CTRL && wdata_i[0]) begin
        n.cs_n = 1'b1;
      end
      if (addr_i == REG_DATA) begin
        n.phase = HP_SHIFT;
        n.cs_n  = 1'b0;
        n.tx    = wdata_i;
        n.mosi  = wdata_i[7];
        n.div   = 3'd0;
        n.bitn  = 3'd0;
      end
    end
    if (s.phase == HP_SHIFT) begin
      n.div = s.div + 3'd1;
      if (s.div == HALF_LAST) begin
        n.div = 3'd0;
        if (!s.sclk) begin
          n.sclk = 1'b1;
          n.rx   = {s.rx[6:0], spi.miso};
        end else begin
          n.sclk = 1'b0;
          n.bitn = s.bitn + 3'd1;
          n.tx   = {s.tx[6:0], 1'b0};
          n.mosi = s.tx[6];
          if (s.bitn == 3'd7) begin
            n.phase   = HP_IDLE;
            n.rx_last = s.rx;
          end
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s      <= '0;
      s.cs_n <= 1'b1;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign spi.cs_n = s.cs_n;
  assign spi.sclk = s.sclk;
  assign spi.mosi = s.mosi;
  assign rdata_o  = s.rdata;

endmodule : spa_host

// ---- core/spa_pkg.sv ----
// Shared constants, types and opcode set of the security page access link
package spa_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_ID_READ      = 8'h83;
  localparam logic [7:0] OP_ID_WRITE     = 8'h82;
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_BUSY_POLL    = 8'h08;
  localparam logic [7:0] OP_FREEZE       = 8'h1A;

  // ****************************************
  // Area layout and fixed contents
  // ****************************************
  localparam int unsigned    PAGE_BYTES    = 256;
  localparam logic [7:0]     ERASED_BYTE   = 8'hFF;
  localparam logic [7:0]     RESERVED_BYTE = 8'hFF;
  // Arbitrary value, stands in for the factory number
  localparam logic [127:0]   SERIAL_NUMBER = 128'h0123456789ABCDEF_FEDCBA9876543210;
  localparam logic [1:0]     GUARD_ALL     = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned    CLK_MHZ       = 200;
  localparam int unsigned    WRITE_TIME_NS = 1000;
  localparam int unsigned    WRITE_CYCLES  = WRITE_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned    SCLK_HALF_NS  = 20;
  localparam int unsigned    HALF_CYCLES   = SCLK_HALF_NS * CLK_MHZ / 1000;

  // ****************************************
  // Host register offsets
  // ****************************************
  localparam logic [3:0]     REG_CTRL      = 4'h0;
  localparam logic [3:0]     REG_DATA      = 4'h4;
  localparam logic [3:0]     REG_STAT      = 4'h8;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {DP_OP, DP_ADDR, DP_DATA, DP_OUT, DP_SKIP} spa_dphase_t;
  typedef enum logic {HP_IDLE, HP_SHIFT} spa_hphase_t;

  typedef struct packed {
    spa_dphase_t phase;
    logic [4:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  op;
    logic [8:0]  addr;
    logic        a10;
    logic [1:0]  nbytes;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [2:0]  obit;
    logic [7:0]  osr;
    logic        miso;
    logic        sclk_q;
    logic        cs_q;
    logic        wp_s1;
    logic        wp_s2;
    logic        honor;
    logic [1:0]  guard;
    logic        scheme;
    logic        frozen;
    logic        write_permit_latch;
    logic        locked;
    logic        busy;
    logic [15:0] bcnt;
  } spa_dev_st_t;

  typedef struct packed {
    spa_hphase_t phase;
    logic [2:0]  div;
    logic [2:0]  bitn;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  rx_last;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic [7:0]  rdata;
  } spa_host_st_t;

endpackage : spa_pkg

// ---- core/spa_spi_if.sv ----
// Serial link between host controller and security page device
`timescale 1ns/1ps
interface spa_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev  (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : spa_spi_if

// ---- dv/security_page_access_bench.sv ----
// Self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module security_page_access_bench;
  import spa_pkg::*;
  logic       clock_i;
  logic       reset_n_i;
  logic       wp_n_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       locked_o;
  logic       busy_o;
  logic       write_permit_latch_o;
  logic       guard_scheme_select_o;
  logic [7:0] rx;
  int         mismatches;
  int         compares;
  int         cycles;

  spa_spi_if spi_link();
  spa_host spa_host_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .spi(spi_link));
  spa_dev spa_dev_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .wp_n_i(wp_n_i), .spi(spi_link), .locked_o(locked_o), .busy_o(busy_o),
    .write_permit_latch_o(write_permit_latch_o),
    .guard_scheme_select_o(guard_scheme_select_o));
  spa_properties spa_properties_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .cs_n(spi_link.cs_n), .sclk(spi_link.sclk), .mosi(spi_link.mosi), .miso(spi_link.miso),
    .locked_o(locked_o), .busy_o(busy_o), .write_permit_latch_o(write_permit_latch_o),
    .guard_scheme_select_o(guard_scheme_select_o));

  initial clock_i = 1'b0;
  always #2.5 clock_i = ~clock_i;

  // ****************************************
  // Register port and link tasks
  // ****************************************
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : reg_rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] tx, output logic [7:0] d);
    logic [7:0] st;
    reg_wr(REG_DATA, tx);
    st = 8'h01;
    for (int n = 0; n < 100 && st[0] !== 1'b0; n++) reg_rd(REG_STAT, st);
    // A shift that never ends is a failure, not a silent fall-through
    if (st[0] !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, st, 8'h00);
    end
    reg_rd(REG_DATA, d);
  endtask : send
  task automatic done;
    reg_wr(REG_CTRL, 8'h01);
    repeat (4) @(posedge clock_i);
  endtask : done
  task automatic wait_idle;
    for (int n = 0; n < 400 && busy_o !== 1'b0; n++) @(posedge clock_i);
    if (busy_o !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, busy_o, 1'b0);
    end
  endtask : wait_idle
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    send(op, rx);
    send(a[23:16], rx);
    send(a[15:8], rx);
    send(a[7:0], rx);
  endtask : cmd
  task automatic permit;
    send(OP_WRITE_PERMIT, rx);
    done();
  endtask : permit
  task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
    cmd(OP_ID_READ, a);
    send(8'h00, rx);
    chk(rx, exp);
    done();
  endtask : rd_chk
  task automatic q_chk(input logic exp);
    cmd(OP_ID_READ, 24'h000400);
    send(8'h00, rx);
    chk({7'h00, rx[0]}, {7'h00, exp});
    done();
  endtask : q_chk
  task automatic wr_id(input logic [23:0] a, input logic [7:0] d);
    permit();
    cmd(OP_ID_WRITE, a);
    send(d, rx);
    done();
  endtask : wr_id
  task automatic set_st(input logic [7:0] b0, input logic [7:0] b1);
    permit();
    send(OP_STATUS_WRITE, rx);
    send(b0, rx);
    send(b1, rx);
    done();
    wait_idle();
  endtask : set_st
  task automatic lock_seq;
    permit();
    cmd(OP_ID_WRITE, 24'h000400);
    send(8'h02, rx);
    done();
  endtask : lock_seq
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Ceiling well above the roughly 11k cycles the tests need
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n_i = 1'b0;
    wp_n_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    chk({7'h00, locked_o}, 8'h00);
    cmd(OP_ID_READ, 24'h000000);
    for (int i = 0; i < 16; i++) begin
      send(i[7:0], rx);
      chk(rx, SERIAL_NUMBER[127-8*i -: 8]);
    end
    done();
    cmd(OP_ID_READ, 24'h00F9FF);
    send(8'h00, rx);
    chk(rx, ERASED_BYTE);
    send(8'h00, rx);
    chk(rx, SERIAL_NUMBER[127 -: 8]);
    done();
    $display("Read and wrap test done");
    permit();
    chk({7'h00, write_permit_latch_o}, 8'h01);
    cmd(OP_ID_WRITE, 24'h000100);
    send(8'hA5, rx);
    done();
    send(OP_BUSY_POLL, rx);
    send(8'h00, rx);
    chk(rx, 8'hFF);
    done();
    wait_idle();
    chk({7'h00, write_permit_latch_o}, 8'h00);
    cmd(OP_ID_WRITE, 24'h000400);
    send(8'h02, rx);
    done();
    chk({6'h00, busy_o, locked_o}, 8'h00);
    rd_chk(24'h000100, 8'hA5);
    wr_id(24'h000010, 8'h00);
    chk({7'h00, busy_o}, 8'h00);
    rd_chk(24'h000010, RESERVED_BYTE);
    permit();
    cmd(OP_ID_WRITE, 24'h000400);
    done();
    chk({6'h00, busy_o, locked_o}, 8'h00);
    q_chk(1'b0);
    $display("Write and abort test done");
    set_st(8'h0C, 8'h00);
    permit();
    send(OP_STATUS_READ, rx);
    send(8'h00, rx);
    chk(rx, 8'h0E);
    done();
    wr_id(24'h000101, 8'h11);
    chk({7'h00, busy_o}, 8'h00);
    rd_chk(24'h000101, ERASED_BYTE);
    set_st(8'h00, 8'h80);
    chk({7'h00, guard_scheme_select_o}, 8'h01);
    set_st(8'h00, 8'h00);
    chk({7'h00, guard_scheme_select_o}, 8'h00);
    $display("Guard test done");
    set_st(8'h80, 8'h00);
    @(posedge clock_i);
    wp_n_i <= 1'b0;
    lock_seq();
    chk({7'h00, locked_o}, 8'h00);
    @(posedge clock_i);
    wp_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    lock_seq();
    chk({7'h00, locked_o}, 8'h01);
    wait_idle();
    q_chk(1'b1);
    wr_id(24'h000102, 8'h77);
    chk({7'h00, busy_o}, 8'h00);
    rd_chk(24'h000102, ERASED_BYTE);
    $display("Lock test done");
    permit();
    send(OP_FREEZE, rx);
    done();
    wait_idle();
    set_st(8'h00, 8'h80);
    chk({7'h00, guard_scheme_select_o}, 8'h00);
    $display("Freeze test done");
    complete_run();
  end
endmodule : security_page_access_bench

// ---- dv/spa_properties.sv ----
// Concurrent checks on the serial link and the device status levels
`timescale 1ns/1ps
module spa_properties
  import spa_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic locked_o,
  input wire logic busy_o,
  input wire logic write_permit_latch_o,
  input wire logic guard_scheme_select_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // ****************************************
  // Write cycle length counter
  // ****************************************
  logic [8:0] busy_cnt;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_cnt <= 9'h000;
    end else begin
      busy_cnt <= busy_o ? busy_cnt + 9'h001 : 9'h000;
    end
  end

  // ****************************************
  // Sequences and properties
  // ****************************************
  sequence s_cycle_end;
    busy_o ##1 !busy_o;
  endsequence
  sequence s_deselected;
    cs_n [*3];
  endsequence

  a_cycle_length: assert property ($fell(busy_o) |->
    busy_cnt >= 9'h0C7 && busy_cnt <= 9'h0C9)
    else $error("write cycle length off");
  a_busy_bounded: assert property (busy_cnt <= 9'h0C9)
    else $error("write cycle overran");
  a_latch_clears: assert property (s_cycle_end |-> !write_permit_latch_o)
    else $error("permit latch kept after cycle");
  a_busy_needs_latch: assert property ($rose(busy_o) |-> write_permit_latch_o && cs_n)
    else $error("write cycle without permit or frame end");
  a_lock_sticky: assert property (locked_o |=> locked_o)
    else $error("lock was cleared");
  a_lock_starts: assert property ($rose(locked_o) |-> busy_o && cs_n)
    else $error("lock without write cycle at frame end");
  a_busy_frozen: assert property (busy_o && $past(busy_o) |->
    $stable(locked_o) && $stable(guard_scheme_select_o))
    else $error("state changed while busy");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside frame");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  a_miso_low_change: assert property (!cs_n && $changed(miso) |-> !sclk)
    else $error("data out changed while clock high");
  a_miso_idle: assert property (s_deselected |-> !miso)
    else $error("data out driven outside frame");
endmodule : spa_properties
